// ### hdl/pgm_pkg.sv
// Constants, states and register offsets of the gigabit PCS receive and management block.
// Assumes one 200 MHz clock, pclk, and an APB master on the register side.
//
// What this block does
// - Classic option: eight data bits at 1 Gbps, low nibble only at 100 and 10.
// - Full-byte option: all eight receive data bits valid at every line rate.
// - Receive-valid is high exactly while the outgoing data byte is valid.
// - Receive-error flags received errors and marks carrier extension.
// - Collision is high while transmit-enable and receive-valid are both high.
// - Carrier sense is high whenever receive-valid is high.
// - Local ability word is sent as our configuration value during negotiation.
// - Negotiation machine runs only while the negotiation enable is high.
// - Sublayer reset holds every state machine in its reset state.
// - Negotiation restart sends the negotiation back to its beginning.
// - Negotiation-done goes high once negotiation has finished.
// - Partner's received configuration word is shown on a sixteen-bit output.
// - Page-received is high only while in the complete-acknowledge state.
// - Isolate forces every receive interface output to zero.
// - Isolate makes the transmit side see all its inputs as zero.
// - Isolation is logical only; outputs stay driven.
// - Isolate low ends receive and transmit isolation.
// - Loopback routes transmit code groups into the receive machine input.
// - Loopback low restores the normal receive input path.
// - Incoming code groups are sampled on the rising clock edge.

package pgm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PGM_CTRL_OFS = 8'h00;
  localparam logic [7:0] PGM_ABIL_OFS = 8'h04;
  localparam logic [7:0] PGM_STAT_OFS = 8'h08;
  localparam logic [7:0] PGM_PART_OFS = 8'h0c;
  localparam logic [7:0] PGM_CODE_OFS = 8'h10;

  // Control field positions
  localparam int PGM_CTRL_AN_EN = 0;
  localparam int PGM_CTRL_RESTART = 1;
  localparam int PGM_CTRL_RESET = 2;
  localparam int PGM_CTRL_ISOLATE = 3;
  localparam int PGM_CTRL_LOOP = 4;
  localparam int PGM_CTRL_FULLBYTE = 5;
  localparam int PGM_CTRL_SPEED = 6;
  localparam int PGM_CTRL_INTEN = 8;

  localparam logic [8:0] PGM_CTRL_RST = 9'h001;
  localparam logic [15:0] PGM_ABIL_RST = 16'h0020;

  // Line rates, two-bit speed field
  localparam logic [1:0] PGM_SPD_1000 = 2'h2;
  localparam logic [1:0] PGM_SPD_100 = 2'h1;

  // ----------------------------------------------------------------
  // Code groups and timing
  // ----------------------------------------------------------------
  // Bit 8 set: the marker must go out as a control group, not as data
  localparam logic [9:0] PGM_K28_5 = 10'h1fa;
  localparam logic [9:0] PGM_IDLE = 10'h000;
  localparam logic [9:0] PGM_CFG_MARK = 10'h3c0;
  localparam int PGM_CLK_MHZ = 200;
  localparam int PGM_LINK_TIMER_US = 10;
  localparam int PGM_LINK_CYC = PGM_LINK_TIMER_US * PGM_CLK_MHZ;
  localparam int PGM_MATCH_CNT = 3;

  typedef enum logic [2:0] {
    PGM_AN_IDLE, PGM_AN_RESTART, PGM_AN_ABILITY, PGM_AN_ACK,
    PGM_AN_COMPLETE_ACK, PGM_AN_LINK_OK
  } pgm_an_state_t;

endpackage

// ### hdl/pgm_sync.sv
// Two flip-flop synchroniser for pin levels.
// Assumes a single destination clock.
`timescale 1ns/1ps
`default_nettype none
module pgm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // pgm_sync
`default_nettype wire

// ### hdl/pgm_an_fsm.sv
// Simplified auto-negotiation state machine for the gigabit PCS.
// Assumes received config words arrive already decoded, one per strobe.
`timescale 1ns/1ps
`default_nettype none
module pgm_an_fsm #(
  parameter int LINK_CYC = pgm_pkg::PGM_LINK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sm_reset,
  input wire logic an_enable,
  input wire logic an_restart,
  input wire logic cfg_strobe,
  input wire logic [15:0] cfg_word,
  output logic [15:0] partner_word,
  output logic an_done,
  output logic page_rx,
  output logic send_cfg
);
  pgm_pkg::pgm_an_state_t state_reg, state_next;
  logic [15:0] timer_reg;
  logic [1:0] match_reg;
  logic [15:0] last_reg;
  wire timer_done = (timer_reg == 16'(LINK_CYC - 1));
  wire state_change = (state_next != state_reg);
  wire matched = (match_reg == 2'(pgm_pkg::PGM_MATCH_CNT - 1));
  wire same_word = cfg_strobe && (cfg_word == last_reg);
  wire ack_seen = same_word && cfg_word[14];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pgm_pkg::PGM_AN_IDLE: state_next = pgm_pkg::PGM_AN_RESTART;
      pgm_pkg::PGM_AN_RESTART: if (timer_done) state_next = pgm_pkg::PGM_AN_ABILITY;
      pgm_pkg::PGM_AN_ABILITY: if (same_word && matched) state_next = pgm_pkg::PGM_AN_ACK;
      pgm_pkg::PGM_AN_ACK: if (ack_seen && matched) state_next = pgm_pkg::PGM_AN_COMPLETE_ACK;
      pgm_pkg::PGM_AN_COMPLETE_ACK: if (timer_done) state_next = pgm_pkg::PGM_AN_LINK_OK;
      pgm_pkg::PGM_AN_LINK_OK: state_next = pgm_pkg::PGM_AN_LINK_OK;
      default: state_next = pgm_pkg::PGM_AN_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= pgm_pkg::PGM_AN_IDLE;
      timer_reg <= '0;
      match_reg <= '0;
      last_reg <= '0;
      partner_word <= '0;
    end else if (sm_reset || !an_enable || an_restart) begin
      state_reg <= pgm_pkg::PGM_AN_IDLE;
      timer_reg <= '0;
      match_reg <= '0;
      last_reg <= '0;
    end else begin
      state_reg <= state_next;
      timer_reg <= (state_change || timer_done) ? '0 : timer_reg + 16'h0001;
      if (cfg_strobe) begin
        last_reg <= cfg_word;
        match_reg <= (cfg_word == last_reg && !matched) ? match_reg + 2'h1 :
                     (cfg_word == last_reg) ? match_reg : '0;
      end
      if (state_reg == pgm_pkg::PGM_AN_ABILITY && same_word && matched) begin
        partner_word <= cfg_word;
      end
    end
  end

  assign an_done = (state_reg == pgm_pkg::PGM_AN_LINK_OK);
  assign page_rx = (state_reg == pgm_pkg::PGM_AN_COMPLETE_ACK);
  assign send_cfg = (state_reg != pgm_pkg::PGM_AN_LINK_OK);
endmodule // pgm_an_fsm
`default_nettype wire

// ### hdl/pgm_top.sv
// Receive interface, loopback, isolate and management of the gigabit PCS.
// Assumes code groups arrive decoded to a byte plus control flag on pclk.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pgm_top #(
  parameter int LINK_CYC = pgm_pkg::PGM_LINK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Incoming ten-bit code group: bit 8 is control, bit 9 error
  input wire logic [9:0] rx_code_in,
  // MAC transmit side
  input wire logic tx_en_in,
  input wire logic tx_er_in,
  input wire logic [7:0] tx_data_in,
  output logic [9:0] tx_code_out,
  // MAC receive side
  output logic [7:0] recv_data_out,
  output logic recv_valid_out,
  output logic recv_error_out,
  output logic collision_out,
  output logic carrier_out,
  output logic irq_out,
  // Management status
  output logic autoneg_done_out,
  output logic page_received_out,
  output logic [15:0] partner_ability_word
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [8:0] ctrl_reg;
  logic [15:0] local_ability_word;
  logic [1:0] sticky_reg;
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire hit_ctrl = (paddr == pgm_pkg::PGM_CTRL_OFS);
  wire hit_abil = (paddr == pgm_pkg::PGM_ABIL_OFS);
  wire hit_stat = (paddr == pgm_pkg::PGM_STAT_OFS);
  wire hit_part = (paddr == pgm_pkg::PGM_PART_OFS);
  wire hit_code = (paddr == pgm_pkg::PGM_CODE_OFS);
  wire hit_any = hit_ctrl | hit_abil | hit_stat | hit_part | hit_code;
  wire autoneg_enable_in = ctrl_reg[pgm_pkg::PGM_CTRL_AN_EN];
  wire sublayer_reset_in = ctrl_reg[pgm_pkg::PGM_CTRL_RESET];
  wire isolate = ctrl_reg[pgm_pkg::PGM_CTRL_ISOLATE];
  wire loopback = ctrl_reg[pgm_pkg::PGM_CTRL_LOOP];
  wire full_byte_option = ctrl_reg[pgm_pkg::PGM_CTRL_FULLBYTE];
  wire [1:0] speed = ctrl_reg[pgm_pkg::PGM_CTRL_SPEED +: 2];
  wire int_enable = ctrl_reg[pgm_pkg::PGM_CTRL_INTEN];
  // Restart is a self-clearing pulse so software need not write twice
  logic restart_reg;
  wire autoneg_restart_in = restart_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= pgm_pkg::PGM_CTRL_RST;
      local_ability_word <= pgm_pkg::PGM_ABIL_RST;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_en && hit_ctrl && pwdata[pgm_pkg::PGM_CTRL_RESTART];
      if (wr_en && hit_ctrl) begin
        ctrl_reg <= pwdata[8:0] & ~(9'h1 << pgm_pkg::PGM_CTRL_RESTART);
      end
      if (wr_en && hit_abil) begin
        local_ability_word <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive path: pin sync, loopback select, isolate
  // ----------------------------------------------------------------
  logic [9:0] rx_code_sync;
  pgm_sync #(.WIDTH(10)) u_rx_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(rx_code_in),
    .sync_out(rx_code_sync)
  );

  logic [9:0] tx_code_reg;
  // Loopback takes the transmit machine's group, bypassing the pins
  wire [9:0] rx_group = loopback ? tx_code_reg : rx_code_sync;
  logic [9:0] rx_group_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_group_reg <= pgm_pkg::PGM_IDLE;
    end else begin
      rx_group_reg <= rx_group;
    end
  end

  wire rx_ctrl = rx_group_reg[8];
  wire rx_bad = rx_group_reg[9];
  wire rx_is_cfg = rx_ctrl && (rx_group_reg[7:0] == pgm_pkg::PGM_K28_5[7:0]);
  wire rx_ext = rx_ctrl && !rx_is_cfg && (rx_group_reg[7:0] != 8'h00);
  wire rx_data_grp = !rx_ctrl && !rx_bad;

  // Config word is two data bytes following a K28.5, low byte first
  logic [1:0] cfg_phase_reg;
  logic [7:0] cfg_lo_reg;
  logic cfg_strobe_reg;
  logic [15:0] cfg_word_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_phase_reg <= '0;
      cfg_lo_reg <= '0;
      cfg_strobe_reg <= 1'b0;
      cfg_word_reg <= '0;
    end else if (sublayer_reset_in) begin
      cfg_phase_reg <= '0;
      cfg_strobe_reg <= 1'b0;
    end else begin
      cfg_strobe_reg <= 1'b0;
      if (rx_is_cfg) begin
        cfg_phase_reg <= 2'h1;
      end else if (cfg_phase_reg == 2'h1 && rx_data_grp) begin
        cfg_lo_reg <= rx_group_reg[7:0];
        cfg_phase_reg <= 2'h2;
      end else if (cfg_phase_reg == 2'h2 && rx_data_grp) begin
        cfg_word_reg <= {rx_group_reg[7:0], cfg_lo_reg};
        cfg_strobe_reg <= 1'b1;
        cfg_phase_reg <= '0;
      end else begin
        cfg_phase_reg <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Auto-negotiation
  // ----------------------------------------------------------------
  logic send_cfg;
  logic an_done;
  logic page_rx;
  logic [15:0] partner_word;
  pgm_an_fsm #(.LINK_CYC(LINK_CYC)) u_an (
    .pclk(pclk),
    .presetn(presetn),
    .sm_reset(sublayer_reset_in),
    .an_enable(autoneg_enable_in),
    .an_restart(autoneg_restart_in),
    .cfg_strobe(cfg_strobe_reg),
    .cfg_word(cfg_word_reg),
    .partner_word(partner_word),
    .an_done(an_done),
    .page_rx(page_rx),
    .send_cfg(send_cfg)
  );
  wire link_up = an_done || !autoneg_enable_in;

  // ----------------------------------------------------------------
  // MII receive outputs
  // ----------------------------------------------------------------
  // Receive data flows only once the link is up and outside config frames
  wire rx_frame = link_up && cfg_phase_reg == 2'h0 && rx_data_grp;
  wire rx_err = link_up && (rx_bad || rx_ext);
  // Classic option below 1 Gbps carries only the low nibble
  wire nibble_only = !full_byte_option && (speed != pgm_pkg::PGM_SPD_1000);
  wire [7:0] rx_byte = nibble_only ? {4'h0, rx_group_reg[3:0]} : rx_group_reg[7:0];
  // Carrier extension carries its marker byte with the error flag
  wire [7:0] rx_byte_out = rx_frame ? rx_byte : (rx_ext ? 8'h0f : 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recv_data_out <= '0;
      recv_valid_out <= 1'b0;
      recv_error_out <= 1'b0;
    end else if (isolate || sublayer_reset_in) begin
      recv_data_out <= '0;
      recv_valid_out <= 1'b0;
      recv_error_out <= 1'b0;
    end else begin
      recv_data_out <= rx_byte_out;
      recv_valid_out <= rx_frame;
      recv_error_out <= rx_err;
    end
  end

  // Isolated MAC inputs read as zero, so collision drops too
  wire tx_en_eff = tx_en_in && !isolate;
  assign collision_out = tx_en_eff && recv_valid_out;
  assign carrier_out = recv_valid_out;

  // ----------------------------------------------------------------
  // Transmit code groups
  // ----------------------------------------------------------------
  wire tx_er_eff = tx_er_in && !isolate;
  wire [7:0] tx_data_eff = isolate ? 8'h00 : tx_data_in;
  logic [1:0] tx_phase_reg;
  logic [9:0] tx_next;

  always_comb begin
    tx_next = pgm_pkg::PGM_IDLE;
    if (send_cfg && autoneg_enable_in) begin
      case (tx_phase_reg)
        2'h0: tx_next = pgm_pkg::PGM_K28_5;
        2'h1: tx_next = {2'b00, local_ability_word[7:0]};
        2'h2: tx_next = {2'b00, local_ability_word[15:8]};
        default: tx_next = pgm_pkg::PGM_IDLE;
      endcase
    end else if (tx_en_eff) begin
      tx_next = {tx_er_eff, 1'b0, tx_data_eff};
    end else if (tx_er_eff) begin
      tx_next = {2'b01, 8'h0f};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_code_reg <= pgm_pkg::PGM_IDLE;
      tx_phase_reg <= '0;
    end else if (sublayer_reset_in) begin
      tx_code_reg <= pgm_pkg::PGM_IDLE;
      tx_phase_reg <= '0;
    end else begin
      tx_code_reg <= tx_next;
      tx_phase_reg <= tx_phase_reg + 2'h1;
    end
  end
  assign tx_code_out = tx_code_reg;

  // ----------------------------------------------------------------
  // Status, interrupt and read mux
  // ----------------------------------------------------------------
  // Bit 0 done, bit 1 page received; write one clears, set wins
  wire clr_stat = wr_en && hit_stat;
  wire [1:0] ev = {page_rx, an_done};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_reg <= '0;
    end else begin
      sticky_reg <= (sticky_reg & ~(clr_stat ? pwdata[1:0] : 2'b00)) | ev;
    end
  end
  assign irq_out = int_enable && (|sticky_reg);

  assign autoneg_done_out = an_done;
  assign page_received_out = page_rx;
  assign partner_ability_word = partner_word;

  wire [31:0] rd_mux = hit_ctrl ? {23'h0, ctrl_reg} :
                       hit_abil ? {16'h0, local_ability_word} :
                       hit_stat ? {28'h0, page_rx, an_done, sticky_reg} :
                       hit_part ? {16'h0, partner_word} :
                       hit_code ? {22'h0, rx_group_reg} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end
  assign pready = 1'b1;
  assign pslverr = (rd_en || wr_en) && !hit_any;
endmodule // pgm_top
`default_nettype wire

// ### bench/pgm_chk.sv
// Port checker for pgm_top, attached by bind.
// Assumes control writes land at the APB access edge.
`timescale 1ns/1ps
`default_nettype none
module pgm_chk #(
  parameter int LINK_CYC = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic tx_en_in,
  input wire logic [7:0] recv_data_out,
  input wire logic recv_valid_out,
  input wire logic recv_error_out,
  input wire logic collision_out,
  input wire logic carrier_out,
  input wire logic autoneg_done_out,
  input wire logic page_received_out,
  input wire logic [15:0] partner_ability_word
);
  // ----------
  // Control shadow
  // ----------
  logic [8:0] ctl_reg;
  wire ctl_wr = psel && penable && pready && pwrite && paddr == pgm_pkg::PGM_CTRL_OFS;
  wire iso = ctl_reg[3];
  wire srst = ctl_reg[2];
  wire nib = !ctl_reg[5] && ctl_reg[7:6] != pgm_pkg::PGM_SPD_1000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctl_reg <= pgm_pkg::PGM_CTRL_RST;
    else if (ctl_wr)
      ctl_reg <= pwdata[8:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Isolate makes transmit-enable read as zero, so collision drops at once
  AST_COL_SET: assert property (tx_en_in && recv_valid_out && !iso |-> collision_out)
    else $error("collision missing");
  AST_COL_CLR: assert property (collision_out |-> tx_en_in && recv_valid_out && !iso)
    else $error("collision without cause");
  AST_CRS: assert property (carrier_out == recv_valid_out)
    else $error("carrier sense wrong");
  // One cycle of slack: the forcing may sit before the output register
  AST_ISO: assert property (iso && $past(iso) |->
    !recv_valid_out && !recv_error_out && recv_data_out == 8'h00) else $error("isolate leak");
  AST_SRST: assert property (srst && $past(srst) |->
    !recv_valid_out && !autoneg_done_out && !page_received_out) else $error("reset leak");
  AST_PAGE_X: assert property (page_received_out |-> !autoneg_done_out)
    else $error("page and done together");
  AST_RESTART: assert property (ctl_wr && pwdata[1] && pwdata[0] |->
    ##[1:3] !autoneg_done_out) else $error("restart ignored");
  AST_LPW: assert property (autoneg_done_out && $past(autoneg_done_out) |->
    $stable(partner_ability_word)) else $error("partner word moved");
  AST_NIB: assert property (recv_valid_out && nib && $stable(ctl_reg) &&
    $past(ctl_reg, 2) == ctl_reg |-> recv_data_out[7:4] == 4'h0) else $error("nibble leak");
  COV_PAGE: cover property ($rose(page_received_out));
  COV_COL: cover property (collision_out);
  COV_ISO: cover property (iso && $past(iso));
endmodule // pgm_chk
bind pgm_top pgm_chk #(.LINK_CYC(LINK_CYC)) pgm_chk_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .tx_en_in, .recv_data_out, .recv_valid_out,
  .recv_error_out, .collision_out, .carrier_out, .autoneg_done_out, .page_received_out,
  .partner_ability_word);
`default_nettype wire

// ### bench/pgm_far_end.sv
// Far side model: the serial link partner and the MAC transmitter.
// Assumes the caller invokes one task at a time.
`timescale 1ns/1ps
`default_nettype none
module pgm_far_end (
  input wire logic pclk,
  output logic [9:0] rx_code_in,
  output logic tx_en_in,
  output logic tx_er_in,
  output logic [7:0] tx_data_in
);
  initial begin
    rx_code_in = 10'h000;
    tx_en_in = 1'b0;
    tx_er_in = 1'b0;
    tx_data_in = 8'h00;
  end
  // One group per clock; idle transmit data toggles so stale bytes never look valid
  task automatic step(input logic [9:0] c, input logic en, input logic [7:0] d);
    @(posedge pclk);
    rx_code_in <= c;
    tx_en_in <= en;
    tx_data_in <= en ? d : ~tx_data_in;
  endtask
  // Config word: marker group, then low byte, then high byte
  task automatic cfg(input logic [15:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      step(10'h1fa, 1'b0, 8'h00);
      step({2'b00, w[7:0]}, 1'b0, 8'h00);
      step({2'b00, w[15:8]}, 1'b0, 8'h00);
    end
  endtask
endmodule // pgm_far_end
`default_nettype wire

// ### bench/pgm_top_tb.sv
// Self-checking bench for pgm_top.
// Assumes pgm_chk is bound and pgm_far_end plays link partner and MAC.
`timescale 1ns/1ps
`default_nettype none
module pgm_top_tb;
  localparam int LC = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re, page_seen, hit;
  logic [7:0] paddr, tx_data_in, recv_data_out;
  logic [31:0] pwdata, prdata, rq, seed;
  logic [9:0] rx_code_in, tx_code_out;
  logic tx_en_in, tx_er_in, recv_valid_out, recv_error_out, collision_out, carrier_out, irq_out;
  logic autoneg_done_out, page_received_out;
  logic [15:0] partner_ability_word, aw, pw;
  int n_mismatch = 0;
  int cmp_count = 0;
  int t;
  pgm_top #(.LINK_CYC(LC)) pgm_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_code_in, .tx_en_in, .tx_er_in, .tx_data_in,
    .tx_code_out, .recv_data_out, .recv_valid_out, .recv_error_out, .collision_out,
    .carrier_out, .irq_out, .autoneg_done_out, .page_received_out, .partner_ability_word);
  pgm_far_end pgm_far_end_inst (.pclk, .rx_code_in, .tx_en_in, .tx_er_in, .tx_data_in);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (page_received_out === 1'b1) page_seen <= 1'b1;
  // ----------
  // Helpers
  // ----------
  function automatic void nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_mismatch++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
    apb(1'b0, a, 32'h0);
    check(w, rq, e);
  endtask
  task automatic ctl(input logic [8:0] v);
    apb(1'b1, pgm_pkg::PGM_CTRL_OFS, {23'h0, v});
  endtask
  // Queue model: each random group but the last four must reach the outputs four edges later
  task automatic stream(input logic [8:0] cv, input logic zero);
    logic [9:0] q[$];
    logic [9:0] c;
    logic [7:0] ed;
    ctl(cv);
    for (int i = 0; i < 16; i++) begin
      nxt();
      c = {seed[3:0] == 4'h0, 1'b0, seed[15:8] | 8'h01};
      pgm_far_end_inst.step(c, seed[4], seed[23:16]);
      q.push_back(c);
      #1;
      if (i >= 4) begin
        c = q.pop_front();
        ed = (!cv[5] && cv[7:6] != pgm_pkg::PGM_SPD_1000) ? {4'h0, c[3:0]} : c[7:0];
        if (zero) {c, ed} = '0;
        // A code error carries no data byte, only the error flag
        if (c[9]) ed = 8'h00;
        check("recv_data", recv_data_out, ed);
        check("recv_valid", recv_valid_out, !zero && !c[9]);
        check("recv_error", recv_error_out, c[9]);
        check("carrier", carrier_out, !zero && !c[9]);
        check("collision", collision_out, !zero && !c[9] && seed[4]);
      end
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    {psel, penable, pwrite, presetn, page_seen} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'd75354;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(pgm_pkg::PGM_CTRL_OFS, {23'h0, pgm_pkg::PGM_CTRL_RST}, "ctrl");
    rd(pgm_pkg::PGM_ABIL_OFS, {16'h0, pgm_pkg::PGM_ABIL_RST}, "ability");
    rd(pgm_pkg::PGM_STAT_OFS, 32'h0, "status");
    rd(8'h20, 32'h0, "unmapped");
    check("slverr", re, 1'b1);
    nxt();
    aw = seed[15:0];
    apb(1'b1, pgm_pkg::PGM_ABIL_OFS, {16'h0, aw});
    rd(pgm_pkg::PGM_ABIL_OFS, {16'h0, aw}, "ability");
    t = 0;
    while (tx_code_out[8:0] !== 9'h1fa && t < 200) begin
      @(posedge pclk);
      #1;
      t++;
    end
    @(posedge pclk);
    #1;
    check("cfg_low", tx_code_out[7:0], aw[7:0]);
    @(posedge pclk);
    #1;
    check("cfg_high", tx_code_out[7:0], aw[15:8]);
    nxt();
    pw = seed[15:0] & 16'hbfff;
    pgm_far_end_inst.cfg(pw, 4);
    pgm_far_end_inst.cfg(pw | 16'h4000, 4);
    pgm_far_end_inst.step(10'h000, 1'b0, 8'h00);
    t = 0;
    while (autoneg_done_out !== 1'b1 && t < 200) begin
      @(posedge pclk);
      #1;
      t++;
    end
    check("done", autoneg_done_out, 1'b1);
    check("page", page_seen, 1'b1);
    check("partner", partner_ability_word, pw);
    rd(pgm_pkg::PGM_STAT_OFS, 32'h7, "status");
    ctl(9'h101);
    check("irq_on", irq_out, 1'b1);
    ctl(9'h001);
    check("irq_off", irq_out, 1'b0);
    apb(1'b1, pgm_pkg::PGM_STAT_OFS, 32'h3);
    rd(pgm_pkg::PGM_STAT_OFS, 32'h5, "status_clr");
    ctl(9'h003);
    repeat (3) @(posedge pclk);
    #1;
    check("restart", autoneg_done_out, 1'b0);
    ctl(9'h000);
    page_seen = 1'b0;
    pgm_far_end_inst.cfg(pw, 4);
    pgm_far_end_inst.cfg(pw | 16'h4000, 4);
    repeat (12) @(posedge pclk);
    #1;
    check("page_off", page_seen, 1'b0);
    for (int m = 0; m < 6; m++) stream({1'b0, 2'(m % 3), 1'(m / 3), 5'h00}, 1'b0);
    stream(9'h088, 1'b1);
    stream(9'h080, 1'b0);
    stream(9'h084, 1'b1);
    ctl(9'h090);
    hit = 1'b0;
    repeat (40) begin
      pgm_far_end_inst.step(10'h000, 1'b1, 8'h5a);
      #1;
      if (recv_valid_out === 1'b1 && recv_data_out === 8'h5a) hit = 1'b1;
    end
    check("loopback", hit, 1'b1);
    pgm_far_end_inst.step(10'h000, 1'b0, 8'h00);
    stream(9'h080, 1'b0);
    pgm_far_end_inst.step(10'h10f, 1'b0, 8'h00);
    repeat (4) @(posedge pclk);
    #1;
    check("ext_error", recv_error_out, 1'b1);
    check("ext_data", recv_data_out, 8'h0f);
    check("ext_valid", recv_valid_out, 1'b0);
    stop_test();
  end
  initial begin
    #50000;
    n_mismatch++;
    stop_test();
  end
endmodule // pgm_top_tb
`default_nettype wire
